// [logic/cosc_defines.svh]
// Register indexes, reset values, field positions and counts of clamp control
`ifndef COSC_DEFINES_SVH
`define COSC_DEFINES_SVH
// ============================================================
// Register indexes (byte address is four times the index)
`define COSC_IDX_TGT 8'h18
`define COSC_IDX_PLACE 8'h19
`define COSC_IDX_DUR 8'h1a
`define COSC_IDX_CLOFS 8'h1b
`define COSC_IDX_TEST 8'h1c
`define COSC_IDX_SLICE 8'h1d
`define COSC_IDX_INPWR 8'h1e
// ============================================================
// Reset values
`define COSC_RST_TGT 8'h00
`define COSC_RST_PLACE 8'h08
`define COSC_RST_DUR 8'h20
`define COSC_RST_CLOFS 8'h5b
`define COSC_RST_TEST 8'hff
`define COSC_RST_SLICE 8'h78
`define COSC_RST_INPWR 8'h30
// ============================================================
// Field positions
`define COSC_TGT_SRC 4
`define COSC_TGT_RED 3
`define COSC_TGT_BLUE 1
`define COSC_CO_POL_OVR 7
`define COSC_CO_POL 6
`define COSC_CO_AO_EN 5
`define COSC_CO_RATE_HI 4
`define COSC_CO_RATE_LO 3
`define COSC_SL_POL 2
`define COSC_SL_SEL_HI 1
`define COSC_SL_SEL_LO 0
`define COSC_IP_CH_OVR 7
`define COSC_IP_CH_SEL 6
`define COSC_IP_PD_AUTO 4
`define COSC_IP_PD 3
// ============================================================
// Auto-offset update periods, in clamps or vertical syncs
`define COSC_AO_N0 8'd3
`define COSC_AO_N1 8'd48
`define COSC_AO_N2 8'd192
`define COSC_AO_N3 8'd3
`define COSC_AO_ONE 8'd1
`endif

// [logic/cosc_pkg.sv]
// Types shared by the clamp, offset and sync control block
`default_nettype none
package cosc_pkg;
  typedef enum logic [1:0] {
    CG_IDLE = 2'b00,
    CG_WAIT = 2'b01,
    CG_ACTIVE = 2'b11
  } cosc_gen_state_t;

  typedef enum logic [1:0] {
    SL_GREEN = 2'b00,
    SL_HSYNC = 2'b01,
    SL_REGEN = 2'b10,
    SL_FILT = 2'b11
  } cosc_slice_sel_t;

  typedef struct packed {
    logic [1:0] green_embedded_sync;
    logic [1:0] horizontal_sync;
    logic regen;
    logic filtered;
  } cosc_sync_src_t;
endpackage
`default_nettype wire

// [logic/cosc_clamp_gen.sv]
// Internal clamp pulse generator: placement and duration after hsync
`default_nettype none
module cosc_clamp_gen #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Timing
  input wire logic hsync,
  input wire logic [W-1:0] place,
  input wire logic [W-1:0] dur,
  // Pulse
  output logic pulse
);
  cosc_pkg::cosc_gen_state_t state_reg;
  logic [W-1:0] cnt_reg;
  logic hs_reg;
  logic trail;

  // ============================================================
  // Trailing edge of hsync restarts the sequence at any time
  assign trail = hs_reg & ~hsync;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hs_reg <= 1'b0;
    end else begin
      hs_reg <= hsync;
    end
  end

  // ============================================================
  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= cosc_pkg::CG_IDLE;
      cnt_reg <= '0;
    end else if (trail) begin
      if (place != '0) begin
        state_reg <= cosc_pkg::CG_WAIT;
        cnt_reg <= place - W'(1);
      end else if (dur != '0) begin
        state_reg <= cosc_pkg::CG_ACTIVE;
        cnt_reg <= dur - W'(1);
      end else begin
        state_reg <= cosc_pkg::CG_IDLE;
      end
    end else begin
      case (state_reg)
        cosc_pkg::CG_WAIT: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - W'(1);
          end else if (dur != '0) begin
            state_reg <= cosc_pkg::CG_ACTIVE;
            cnt_reg <= dur - W'(1);
          end else begin
            state_reg <= cosc_pkg::CG_IDLE;
          end
        end
        cosc_pkg::CG_ACTIVE: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - W'(1);
          end else begin
            state_reg <= cosc_pkg::CG_IDLE;
          end
        end
        default: begin
          state_reg <= cosc_pkg::CG_IDLE;
        end
      endcase
    end
  end

  assign pulse = (state_reg == cosc_pkg::CG_ACTIVE);

  // ============================================================
  // Checks
  chk_place_start: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    trail && place == 8'h02 && dur != '0 ##1 !trail [*2] |=> pulse)
    else $error("clamp did not start after placement");

  chk_dur_one: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_reg == cosc_pkg::CG_WAIT && cnt_reg == '0 && !trail
      && dur == 8'h01 ##1 !trail |-> pulse ##1 !pulse)
    else $error("clamp duration of one not kept");

  chk_restart: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    trail && place != '0 |=> !pulse)
    else $error("clamp did not restart at hsync trailing edge");
endmodule
`default_nettype wire

// [logic/cosc_ctrl.sv]
// Clamp, auto-offset, sliced sync, channel and power-down control top
//
// Behaviour
// - Each colour channel clamps to ground on select 0, midscale on 1.
// - Clamp pulse starts placement clocks after hsync trailing edge.
// - Clamp pulse lasts the programmed duration in clocks.
// - Polarity override picks the programmed clamp polarity, else detected.
// - Auto-offset enable turns offset correction on; offsets mean clamp code.
// - Auto-offset runs every 3, 48, 192 clamps or 3 vsyncs.
// - Sliced sync output is negative on polarity 0, positive on 1.
// - Sliced sync source: green sync, hsync, regenerated or filtered.
// - Channel override hands input selection to the channel select bit.
// - Select bit picks channel 0 or 1, also when both have syncs.
// - Power-down control select: 0 manual, 1 automatic, reset automatic.
// - Power-down bit 0 runs normally, 1 powers down.
// - Clamp source bit picks internal clamp or the external clamp input.
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
`include "cosc_defines.svh"
module cosc_ctrl #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sync and clamp inputs
  input wire cosc_pkg::cosc_sync_src_t sync_src,
  input wire logic [1:0] sync_present,
  input wire logic vsync_in,
  input wire logic ext_clamp_in,
  input wire logic clamp_pol_detected,
  input wire logic auto_pd_request,
  // Control outputs
  output logic sliced_sync_output_pin,
  output logic clamp_active,
  output logic [2:0] clamp_midscale,
  output logic clamp_pol_positive,
  output logic auto_offset_enable,
  output logic auto_offset_update,
  output logic channel_select,
  output logic power_down
);
  // ============================================================
  // Register file
  logic [7:0] tgt_reg;
  logic [7:0] place_reg;
  logic [7:0] dur_reg;
  logic [7:0] clofs_reg;
  logic [7:0] test_reg;
  logic [7:0] slice_reg;
  logic [7:0] inpwr_reg;
  logic [7:0] rd_next;
  logic hit_next;
  logic setup;
  logic wr_en;
  logic [7:0] idx;

  // Index decode, shared by read and write paths
  function automatic logic idx_mapped(input logic [7:0] i);
    return i >= `COSC_IDX_TGT && i <= `COSC_IDX_INPWR;
  endfunction

  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    hit_next = idx_mapped(idx) && paddr[1:0] == 2'b00;
    case (idx)
      `COSC_IDX_TGT: rd_next = tgt_reg;
      `COSC_IDX_PLACE: rd_next = place_reg;
      `COSC_IDX_DUR: rd_next = dur_reg;
      `COSC_IDX_CLOFS: rd_next = clofs_reg;
      `COSC_IDX_TEST: rd_next = test_reg;
      `COSC_IDX_SLICE: rd_next = slice_reg;
      `COSC_IDX_INPWR: rd_next = inpwr_reg;
      default: rd_next = 8'h00;
    endcase
    if (!hit_next) begin
      rd_next = 8'h00;
    end
  end

  // Answer is fixed one cycle after setup, so no wait states are needed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_next;
      prdata <= setup ? {24'h00_0000, rd_next} : 32'h0000_0000;
    end
  end

  // Values software must hold fixed are stored as written, not forced
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tgt_reg <= `COSC_RST_TGT;
      place_reg <= `COSC_RST_PLACE;
      dur_reg <= `COSC_RST_DUR;
      clofs_reg <= `COSC_RST_CLOFS;
      test_reg <= `COSC_RST_TEST;
      slice_reg <= `COSC_RST_SLICE;
      inpwr_reg <= `COSC_RST_INPWR;
    end else if (wr_en && paddr[1:0] == 2'b00) begin
      case (idx)
        `COSC_IDX_TGT: tgt_reg <= pwdata[7:0];
        `COSC_IDX_PLACE: place_reg <= pwdata[7:0];
        `COSC_IDX_DUR: dur_reg <= pwdata[7:0];
        `COSC_IDX_CLOFS: clofs_reg <= pwdata[7:0];
        `COSC_IDX_TEST: test_reg <= pwdata[7:0];
        `COSC_IDX_SLICE: slice_reg <= pwdata[7:0];
        `COSC_IDX_INPWR: inpwr_reg <= pwdata[7:0];
        default: tgt_reg <= tgt_reg;
      endcase
    end
  end

  // ============================================================
  // Input channel selection
  logic ch_next;

  always_comb begin
    if (inpwr_reg[`COSC_IP_CH_OVR] || sync_present == 2'b11) begin
      ch_next = inpwr_reg[`COSC_IP_CH_SEL];
    end else begin
      // Without override, follow the only channel carrying syncs
      ch_next = sync_present[1] & ~sync_present[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      channel_select <= 1'b0;
    end else begin
      channel_select <= ch_next;
    end
  end

  // ============================================================
  // Clamp timing and polarity
  logic hs_sel;
  logic gen_pulse;
  logic pol_pos;
  logic clamp_next;

  // Decoded channel is the registered one, so syncs follow the data path
  assign hs_sel = sync_src.horizontal_sync[channel_select];
  assign pol_pos = clofs_reg[`COSC_CO_POL_OVR] ?
                   clofs_reg[`COSC_CO_POL] : clamp_pol_detected;

  cosc_clamp_gen #(
    .W(8)
  ) u_gen (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .hsync(hs_sel),
    .place(place_reg),
    .dur(dur_reg),
    .pulse(gen_pulse)
  );

  // External clamp is taken through the chosen polarity
  assign clamp_next = tgt_reg[`COSC_TGT_SRC] ?
                      ~(ext_clamp_in ^ pol_pos) : gen_pulse;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clamp_active <= 1'b0;
      clamp_pol_positive <= 1'b0;
      clamp_midscale <= 3'h0;
    end else begin
      clamp_active <= clamp_next;
      clamp_pol_positive <= pol_pos;
      clamp_midscale <= tgt_reg[`COSC_TGT_RED:`COSC_TGT_BLUE];
    end
  end

  // ============================================================
  // Auto-offset update scheduling
  logic [1:0] rate;
  logic [7:0] ao_cnt_reg;
  logic vs_reg;
  logic ao_event;

  function automatic logic [7:0] ao_last(input logic [1:0] r);
    case (r)
      2'b00: return `COSC_AO_N0 - `COSC_AO_ONE;
      2'b01: return `COSC_AO_N1 - `COSC_AO_ONE;
      2'b10: return `COSC_AO_N2 - `COSC_AO_ONE;
      default: return `COSC_AO_N3 - `COSC_AO_ONE;
    endcase
  endfunction

  assign rate = clofs_reg[`COSC_CO_RATE_HI:`COSC_CO_RATE_LO];
  // One event per clamp start, or per vsync start in the slowest mode
  assign ao_event = (rate == 2'b11) ? (vsync_in & ~vs_reg)
                                    : (clamp_next & ~clamp_active);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vs_reg <= 1'b0;
    end else begin
      vs_reg <= vsync_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ao_cnt_reg <= 8'h00;
      auto_offset_update <= 1'b0;
    end else if (!clofs_reg[`COSC_CO_AO_EN]) begin
      ao_cnt_reg <= 8'h00;
      auto_offset_update <= 1'b0;
    end else if (ao_event) begin
      if (ao_cnt_reg >= ao_last(rate)) begin
        ao_cnt_reg <= 8'h00;
        auto_offset_update <= 1'b1;
      end else begin
        ao_cnt_reg <= ao_cnt_reg + 8'h01;
        auto_offset_update <= 1'b0;
      end
    end else begin
      auto_offset_update <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      auto_offset_enable <= 1'b0;
    end else begin
      auto_offset_enable <= clofs_reg[`COSC_CO_AO_EN];
    end
  end

  // ============================================================
  // Sliced sync output
  logic slice_src;
  cosc_pkg::cosc_slice_sel_t ssel;

  assign ssel = cosc_pkg::cosc_slice_sel_t'(
    slice_reg[`COSC_SL_SEL_HI:`COSC_SL_SEL_LO]);

  always_comb begin
    case (ssel)
      cosc_pkg::SL_GREEN:
        slice_src = sync_src.green_embedded_sync[channel_select];
      cosc_pkg::SL_HSYNC: slice_src = hs_sel;
      cosc_pkg::SL_REGEN: slice_src = sync_src.regen;
      cosc_pkg::SL_FILT: slice_src = sync_src.filtered;
      default: slice_src = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sliced_sync_output_pin <= 1'b0;
    end else begin
      // Sources are active high; negative polarity inverts
      sliced_sync_output_pin <= ~(slice_src ^ slice_reg[`COSC_SL_POL]);
    end
  end

  // ============================================================
  // Power-down
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      power_down <= 1'b0;
    end else if (inpwr_reg[`COSC_IP_PD_AUTO]) begin
      power_down <= auto_pd_request;
    end else begin
      power_down <= inpwr_reg[`COSC_IP_PD];
    end
  end

  // ============================================================
  // Checks
  chk_clamp_target: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(tgt_reg) |=>
      clamp_midscale == $past(tgt_reg[`COSC_TGT_RED:`COSC_TGT_BLUE]))
    else $error("clamp target not applied");

  chk_clamp_pol: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clofs_reg[`COSC_CO_POL_OVR] && $stable(clofs_reg) |=>
      clamp_pol_positive == $past(clofs_reg[`COSC_CO_POL]))
    else $error("clamp polarity override ignored");

  chk_offset_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !clofs_reg[`COSC_CO_AO_EN] |=>
      !auto_offset_update && ao_cnt_reg == 8'h00)
    else $error("auto-offset ran while disabled");

  chk_offset_gap: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    auto_offset_update && rate != 2'b11 |=> !auto_offset_update [*3])
    else $error("auto-offset updates too close");

  chk_slice_out: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ssel == cosc_pkg::SL_REGEN ##1 1'b1 |->
      sliced_sync_output_pin == ($past(sync_src.regen)
                                 == $past(slice_reg[`COSC_SL_POL])))
    else $error("sliced sync output wrong");

  chk_chan_override: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    inpwr_reg[`COSC_IP_CH_OVR] |=>
      channel_select == $past(inpwr_reg[`COSC_IP_CH_SEL]))
    else $error("channel override ignored");

  chk_pd_auto: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    inpwr_reg[`COSC_IP_PD_AUTO] |=>
      power_down == $past(auto_pd_request))
    else $error("automatic power-down not followed");

  chk_pd_manual: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !inpwr_reg[`COSC_IP_PD_AUTO] ##1 !inpwr_reg[`COSC_IP_PD_AUTO] |->
      power_down == $past(inpwr_reg[`COSC_IP_PD]))
    else $error("manual power-down not followed");

  chk_clamp_ext: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tgt_reg[`COSC_TGT_SRC] |=>
      clamp_active == $past(ext_clamp_in == pol_pos))
    else $error("external clamp not used");
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench of the clamp, offset and sync control block
`default_nettype none
`include "cosc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Signals
  logic clk_sys, rst_n, psel, penable, pwrite;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  cosc_pkg::cosc_sync_src_t sync_src;
  logic [1:0] sync_present;
  logic vsync_in, ext_clamp_in, clamp_pol_detected, auto_pd_request;
  logic sliced_sync_output_pin, clamp_active, clamp_pol_positive;
  logic [2:0] clamp_midscale;
  logic auto_offset_enable, auto_offset_update, channel_select, power_down;
  int num_errors = 0;
  int cmp_count = 0;
  int ao_pulses = 0;
  cosc_ctrl #(.AW(10)) i_cosc_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_src(sync_src),
    .sync_present(sync_present), .vsync_in(vsync_in),
    .ext_clamp_in(ext_clamp_in), .clamp_pol_detected(clamp_pol_detected),
    .auto_pd_request(auto_pd_request),
    .sliced_sync_output_pin(sliced_sync_output_pin),
    .clamp_active(clamp_active), .clamp_midscale(clamp_midscale),
    .clamp_pol_positive(clamp_pol_positive),
    .auto_offset_enable(auto_offset_enable),
    .auto_offset_update(auto_offset_update),
    .channel_select(channel_select), .power_down(power_down)
  );
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Only this process writes the pulse count, so scenarios take a base
  always @(posedge clk_sys) begin
    if (auto_offset_update === 1'b1) ao_pulses <= ao_pulses + 1;
  end
  // ============================================================
  // Shared tasks
  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {idx, 2'b00}, d, r, e);
    chk(32'(e), 32'h0);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, {idx, 2'b00}, 8'h00, r, e);
    chk(r, {24'h0, x});
    chk(32'(e), 32'h0);
  endtask
  task automatic bad(input logic [9:0] a);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    apb(1'b1, a, 8'h55, r, e);
    chk(32'(e), 32'h1);
  endtask
  // ============================================================
  // Scenarios
  task automatic clamp_case(input logic [7:0] p, input logic [7:0] d);
    int first;
    int width;
    wr(`COSC_IDX_PLACE, p);
    wr(`COSC_IDX_DUR, d);
    first = -1;
    width = 0;
    @(posedge clk_sys);
    sync_src.horizontal_sync[0] <= 1'b1;
    @(posedge clk_sys);
    sync_src.horizontal_sync[0] <= 1'b0;
    for (int i = 0; i < p + d + 8; i++) begin
      @(posedge clk_sys);
      #1;
      if (clamp_active === 1'b1) begin
        if (first < 0) first = i;
        width++;
      end
    end
    // Index 0 is the edge that takes the trailing edge; output adds one
    chk(32'(first), 32'(p) + 32'd1);
    chk(32'(width), 32'(d));
  endtask
  task automatic ao_case(input logic [1:0] rate, input logic en,
                         input int nev, input int exp);
    int base;
    wr(`COSC_IDX_TGT, 8'h10);
    wr(`COSC_IDX_CLOFS, {2'b11, en, rate, 3'b011});
    repeat (3) @(posedge clk_sys);
    #1;
    base = ao_pulses;
    for (int i = 0; i < nev; i++) begin
      @(posedge clk_sys);
      if (rate == 2'b11) vsync_in <= 1'b1;
      else ext_clamp_in <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      if (rate != 2'b11) chk(32'(clamp_active), 32'h1);
      @(posedge clk_sys);
      vsync_in <= 1'b0;
      ext_clamp_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    #1;
    chk(32'(ao_pulses - base), 32'(exp));
    chk(32'(auto_offset_enable), 32'(en));
  endtask
  // Kind 0 clamp polarity, 1 channel choice, 2 power-down
  task automatic ctl(input int k, input logic [7:0] v, input logic [1:0] in,
                     input logic exp);
    logic o;
    @(posedge clk_sys);
    if (k == 0) clamp_pol_detected <= in[0];
    else if (k == 1) sync_present <= in;
    else auto_pd_request <= in[0];
    wr(k == 0 ? `COSC_IDX_CLOFS : `COSC_IDX_INPWR, v);
    repeat (3) @(posedge clk_sys);
    #1;
    o = (k == 0) ? clamp_pol_positive : (k == 1) ? channel_select : power_down;
    chk(32'(o), 32'(exp));
  endtask
  task automatic slice_run();
    cosc_pkg::cosc_sync_src_t s;
    wr(`COSC_IDX_INPWR, 8'hb0);
    for (int sel = 0; sel < 4; sel++) begin
      for (int pol = 0; pol < 2; pol++) begin
        wr(`COSC_IDX_SLICE, 8'h78 | 8'(pol * 4 + sel));
        for (int v = 0; v < 2; v++) begin
          s = {6{~1'(v)}};
          if (sel == 0) s.green_embedded_sync[0] = 1'(v);
          else if (sel == 1) s.horizontal_sync[0] = 1'(v);
          else if (sel == 2) s.regen = 1'(v);
          else s.filtered = 1'(v);
          @(posedge clk_sys);
          sync_src <= s;
          repeat (3) @(posedge clk_sys);
          #1;
          chk(32'(sliced_sync_output_pin), 32'(pol ? v : 1 - v));
        end
      end
    end
  endtask
  // ============================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sync_src = '0;
    sync_present = 2'b00;
    vsync_in = 1'b0;
    ext_clamp_in = 1'b0;
    clamp_pol_detected = 1'b0;
    auto_pd_request = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc(`COSC_IDX_TGT, `COSC_RST_TGT);
    rc(`COSC_IDX_PLACE, `COSC_RST_PLACE);
    rc(`COSC_IDX_DUR, `COSC_RST_DUR);
    rc(`COSC_IDX_CLOFS, `COSC_RST_CLOFS);
    rc(`COSC_IDX_TEST, `COSC_RST_TEST);
    rc(`COSC_IDX_SLICE, `COSC_RST_SLICE);
    rc(`COSC_IDX_INPWR, `COSC_RST_INPWR);
    bad({`COSC_IDX_PLACE, 2'b01});
    bad({8'h30, 2'b00});
    rc(`COSC_IDX_PLACE, `COSC_RST_PLACE);
    for (int m = 5; m > 1; m -= 3) begin
      wr(`COSC_IDX_TGT, {4'h0, 3'(m), 1'b0});
      repeat (3) @(posedge clk_sys);
      #1;
      chk(32'(clamp_midscale), 32'(m));
    end
    wr(`COSC_IDX_TGT, 8'h00);
    clamp_case(8'h03, 8'h04);
    clamp_case(8'h00, 8'h01);
    clamp_case(8'h02, 8'h01);
    clamp_case(8'h08, 8'h20);
    rc(`COSC_IDX_DUR, 8'h20);
    ctl(0, 8'h03, 2'b01, 1'b1);
    ctl(0, 8'h03, 2'b00, 1'b0);
    ctl(0, 8'h83, 2'b01, 1'b0);
    ctl(0, 8'hc3, 2'b00, 1'b1);
    ao_case(2'b00, 1'b0, 6, 0);
    ao_case(2'b00, 1'b1, 6, 2);
    ao_case(2'b01, 1'b1, 96, 2);
    ao_case(2'b10, 1'b1, 384, 2);
    ao_case(2'b11, 1'b1, 6, 2);
    ctl(1, 8'h30, 2'b10, 1'b1);
    ctl(1, 8'h30, 2'b01, 1'b0);
    ctl(1, 8'h70, 2'b11, 1'b1);
    ctl(1, 8'hb0, 2'b10, 1'b0);
    ctl(1, 8'hf0, 2'b00, 1'b1);
    ctl(2, 8'h30, 2'b01, 1'b1);
    ctl(2, 8'h38, 2'b00, 1'b0);
    ctl(2, 8'h28, 2'b00, 1'b1);
    ctl(2, 8'h20, 2'b01, 1'b0);
    slice_run();
    wrap_up();
  end
endmodule
`default_nettype wire
